// ---- hdl/acs_defines.svh ----
// constants for the converter two-wire slave front end
// assumes inclusion by bare name from design files
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH
`define ACS_SLAVE_ADDR 7'h36
`define ACS_MCODE_TOP 5'h01
`define ACS_SETUP_RESET 8'h80
`define ACS_CONFIG_RESET 8'h01
`define ACS_BIT_REG 7
`define ACS_BIT_SEL_HI 6
`define ACS_BIT_SEL_LO 4
`define ACS_BIT_CLK 3
`define ACS_BIT_BIP 2
`define ACS_BIT_RST 1
`define ACS_BIT_SCAN_HI 6
`define ACS_BIT_SCAN_LO 5
`define ACS_BIT_CS 1
`define ACS_BIT_SGL 0
`define ACS_LEAD_ONES 6'h3F
`endif

// ---- hdl/acs_pkg.sv ----
// types for the converter two-wire slave front end
// assumes acs_defines.svh is compiled alongside
package acs_pkg;
  // byte engine states
  typedef enum logic [2:0] {
    ACS_IDLE = 3'b000, // waiting for start
    ACS_ADDR = 3'b001, // shifting first byte
    ACS_AACK = 3'b010, // ack slot of first byte
    ACS_WRX = 3'b011, // shifting written byte
    ACS_WACK = 3'b100, // ack slot of written byte
    ACS_RTX = 3'b101, // sending read byte
    ACS_RACK = 3'b110, // master ack slot
    ACS_SKIP = 3'b111 // ignoring traffic
  } acs_state_e;
  typedef logic [7:0] acs_byte_t;
endpackage : acs_pkg

// ---- hdl/acs_bus_if.sv ----
// interface carrying conditioned bus events from the line filter to the engine
// assumes one system clock for both ends
`timescale 1ns/100ps
interface acs_bus_if;
  logic scl_rise; // one-cycle pulse on clock rising
  logic scl_fall; // one-cycle pulse on clock falling
  logic sda_lvl; // synchronised data level
  logic start_ev; // start or repeated start pulse
  logic stop_ev; // stop pulse
  modport filt (output scl_rise, scl_fall, sda_lvl, start_ev, stop_ev);
  modport eng (input scl_rise, scl_fall, sda_lvl, start_ev, stop_ev);
endinterface : acs_bus_if

// ---- hdl/acs_line_sync.sv ----
// two-flop synchronisers and edge/condition detection for the bus pins
// assumes pins are asynchronous to i_clk_sys
`timescale 1ns/100ps
`include "acs_defines.svh"
module acs_line_sync (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // raw pins
  input wire logic i_scl,
  input wire logic i_sda,
  // conditioned events
  acs_bus_if.filt bus
);
  import acs_pkg::*;
  logic [1:0] scl_meta_q, scl_meta_d; // first stage feeds only second
  logic [1:0] sda_meta_q, sda_meta_d;
  logic scl_old_q, scl_old_d; // previous synced levels
  logic sda_old_q, sda_old_d;

  // next values of the sync chains and history
  always_comb begin
    scl_meta_d = {scl_meta_q[0], i_scl};
    sda_meta_d = {sda_meta_q[0], i_sda};
    scl_old_d = scl_meta_q[1];
    sda_old_d = sda_meta_q[1];
  end

  // registers idle high like the pulled-up bus
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      scl_meta_q <= 2'h3;
      sda_meta_q <= 2'h3;
      scl_old_q <= 1'b1;
      sda_old_q <= 1'b1;
    end else begin
      scl_meta_q <= scl_meta_d;
      sda_meta_q <= sda_meta_d;
      scl_old_q <= scl_old_d;
      sda_old_q <= sda_old_d;
    end
  end

  // conditions read only the second stage and its history
  assign bus.scl_rise = scl_meta_q[1] & ~scl_old_q;
  assign bus.scl_fall = ~scl_meta_q[1] & scl_old_q;
  assign bus.sda_lvl = sda_meta_q[1];
  assign bus.start_ev = scl_meta_q[1] & scl_old_q & sda_old_q & ~sda_meta_q[1];
  assign bus.stop_ev = scl_meta_q[1] & scl_old_q & ~sda_old_q & sda_meta_q[1];
endmodule : acs_line_sync

// ---- hdl/acs_slave.sv ----
// two-wire slave front end: address match, ack, speed mode, setup/config bytes
// assumes open-drain pins resolved outside; defaults load at reset (power-up)
// Functional notes
// - start is data falling while clock high
// - stop is data rising while clock high
// - repeated start keeps bus active, mode kept
// - receiver drives ack low through ninth clock
// - nack leaves data released through ninth clock
// - idle slave waits start plus address 0110110
// - address lsb zero write, one read
// - matching address acknowledged for one clock
// - fast timing after power-up
// - master code is nacked, then high speed
// - stop in high speed returns fast timing
// - top bit one setup, zero configuration
// - one or two bytes, any order
// - every written byte is acknowledged
// - setup bit 2 bipolar, default unipolar
// - setup bit1 zero resets configuration
// - setup bit 0 ignored
// - setup bit 3 clock source, default internal
// - config scan 6:5, channel 1, type 0
// - read result: six ones then result bits
`timescale 1ns/100ps
`include "acs_defines.svh"
module acs_slave (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // bus pins, data is open drain
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  // conversion result to send on reads
  input wire logic [9:0] i_result,
  // decoded setup fields
  output logic [2:0] o_reference_choice,
  output logic o_clock_external,
  output logic o_polarity_coding_select,
  // decoded configuration fields
  output logic [1:0] o_scan_pattern,
  output logic o_input_channel_pick,
  output logic o_input_type_select,
  // status
  output logic o_high_speed,
  output logic o_bus_active
);
  import acs_pkg::*;

  acs_bus_if bus ();

  // pin conditioning
  acs_line_sync u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .bus(bus)
  );

  acs_state_e st_q, st_d; // byte engine state
  logic [3:0] bit_q, bit_d; // bits taken in current byte
  acs_byte_t shf_q, shf_d; // receive/transmit shift register
  logic rd_q, rd_d; // current transfer is a read
  logic mcode_q, mcode_d; // first byte was the high speed code
  logic hs_q, hs_d; // high speed timing selected
  logic act_q, act_d; // bus busy between start and stop
  logic low_q, low_d; // driving data line low
  logic byte2_q, byte2_d; // which result byte is being sent
  acs_byte_t setup_q, setup_d; // converter_setup register
  acs_byte_t config_q, config_d; // configuration register
  logic [9:0] res_q, res_d; // result latched at read start

  // byte engine next state
  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    shf_d = shf_q;
    rd_d = rd_q;
    mcode_d = mcode_q;
    hs_d = hs_q;
    act_d = act_q;
    low_d = low_q;
    byte2_d = byte2_q;
    setup_d = setup_q;
    config_d = config_q;
    res_d = res_q;
    if (bus.stop_ev) begin
      st_d = ACS_IDLE;
      act_d = 1'b0;
      low_d = 1'b0;
      hs_d = 1'b0;
    end else if (bus.start_ev) begin
      st_d = ACS_ADDR; // (mode untouched on restart)
      act_d = 1'b1;
      bit_d = 4'h0;
      low_d = 1'b0;
    end else begin
      case (st_q)
        ACS_IDLE: begin
          low_d = 1'b0;
        end
        ACS_ADDR, ACS_WRX: begin
          if (bus.scl_rise) begin
            shf_d = {shf_q[6:0], bus.sda_lvl};
            bit_d = bit_q + 4'h1;
          end
          if (bus.scl_fall && bit_q == 4'h8) begin
            bit_d = 4'h0;
            if (st_q == ACS_ADDR) begin
              st_d = ACS_AACK;
              mcode_d = (shf_q[7:3] == `ACS_MCODE_TOP);
              rd_d = shf_q[0];
              low_d = (shf_q[7:1] == `ACS_SLAVE_ADDR); // (code left released)
            end else begin
              st_d = ACS_WACK;
              low_d = 1'b1;
              if (shf_q[`ACS_BIT_REG]) begin
                setup_d = {1'b1, shf_q[6:2], 1'b0, 1'b0};
                if (!shf_q[`ACS_BIT_RST]) begin
                  config_d = `ACS_CONFIG_RESET;
                end
              end else begin
                config_d = {1'b0, shf_q[6:5], 3'h0, shf_q[1:0]};
              end
            end
          end
        end
        ACS_AACK: begin
          if (bus.scl_fall) begin
            low_d = 1'b0; // one clock of ack
            if (mcode_q) begin
              hs_d = 1'b1;
              st_d = ACS_SKIP; // wait for repeated start
            end else if (shf_q[7:1] != `ACS_SLAVE_ADDR) begin
              st_d = ACS_SKIP;
            end else if (rd_q) begin
              st_d = ACS_RTX;
              res_d = i_result;
              byte2_d = 1'b0;
              shf_d = {`ACS_LEAD_ONES, i_result[9:8]};
              low_d = 1'b0; // first bit is a leading one, so the line stays released
            end else begin
              st_d = ACS_WRX;
            end
          end
        end
        ACS_RTX: begin
          if (bus.scl_fall) begin
            bit_d = bit_q + 4'h1;
            if (bit_q == 4'h7) begin
              st_d = ACS_RACK;
              low_d = 1'b0; // master answers, line released
            end else begin
              shf_d = {shf_q[6:0], 1'b0};
              low_d = ~shf_q[6];
            end
          end
        end
        ACS_RACK: begin
          if (bus.scl_rise) begin
            rd_d = ~bus.sda_lvl; // master ack keeps reading
          end
          if (bus.scl_fall) begin
            bit_d = 4'h0;
            if (!rd_q) begin
              st_d = ACS_SKIP; // nack: stay released
            end else begin
              st_d = ACS_RTX;
              byte2_d = ~byte2_q;
              shf_d = byte2_q ? {`ACS_LEAD_ONES, res_q[9:8]} : res_q[7:0];
              low_d = byte2_q ? 1'b0 : ~res_q[7];
            end
          end
        end
        ACS_WACK: begin
          if (bus.scl_fall) begin
            low_d = 1'b0;
            st_d = ACS_WRX;
          end
        end
        ACS_SKIP: begin
          low_d = 1'b0;
        end
        default: begin
          st_d = ACS_IDLE;
          low_d = 1'b0;
        end
      endcase
    end
  end

  // state registers; power-up defaults on reset
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_q <= ACS_IDLE;
      bit_q <= 4'h0;
      shf_q <= 8'h00;
      rd_q <= 1'b0;
      mcode_q <= 1'b0;
      hs_q <= 1'b0;
      act_q <= 1'b0;
      low_q <= 1'b0;
      byte2_q <= 1'b0;
      setup_q <= `ACS_SETUP_RESET;
      config_q <= `ACS_CONFIG_RESET;
      res_q <= 10'h000;
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      shf_q <= shf_d;
      rd_q <= rd_d;
      mcode_q <= mcode_d;
      hs_q <= hs_d;
      act_q <= act_d;
      low_q <= low_d;
      byte2_q <= byte2_d;
      setup_q <= setup_d;
      config_q <= config_d;
      res_q <= res_d;
    end
  end

  // open drain: only ever pull low
  assign o_sda = 1'b0;
  assign o_sda_oe = low_q;
  assign o_reference_choice = setup_q[`ACS_BIT_SEL_HI:`ACS_BIT_SEL_LO];
  assign o_clock_external = setup_q[`ACS_BIT_CLK];
  assign o_polarity_coding_select = setup_q[`ACS_BIT_BIP];
  assign o_scan_pattern = config_q[`ACS_BIT_SCAN_HI:`ACS_BIT_SCAN_LO];
  assign o_input_channel_pick = config_q[`ACS_BIT_CS];
  assign o_input_type_select = config_q[`ACS_BIT_SGL];
  assign o_high_speed = hs_q;
  assign o_bus_active = act_q;

  // a stop always leaves fast timing and idle
  stop_mode_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    bus.stop_ev |=> !hs_q && st_q == ACS_IDLE) else $error("stop did not restore fast idle");

  // foreign address is never acked
  sequence foreign_addr_s;
    st_q == ACS_ADDR && bus.scl_fall && bit_q == 4'h8 && shf_q[7:1] != `ACS_SLAVE_ADDR;
  endsequence
  foreign_nack_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    foreign_addr_s |=> !o_sda_oe) else $error("foreign address acknowledged");

  // own address is acked in the ninth slot
  own_ack_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    st_q == ACS_ADDR && bus.scl_fall && bit_q == 4'h8 && shf_q[7:1] == `ACS_SLAVE_ADDR && !bus.stop_ev
    && !bus.start_ev |=> o_sda_oe && st_q == ACS_AACK) else $error("own address not acknowledged");

  // written bytes are acknowledged
  write_ack_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    st_q == ACS_WRX && bus.scl_fall && bit_q == 4'h8 && !bus.stop_ev && !bus.start_ev
    |=> o_sda_oe) else $error("written byte not acknowledged");

  // master code selects high speed after its nack
  hs_enter_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    st_q == ACS_AACK && mcode_q && bus.scl_fall && !bus.stop_ev && !bus.start_ev
    |=> hs_q && !o_sda_oe) else $error("master code did not enter high speed");

  // restart keeps timing mode
  restart_mode_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    bus.start_ev && !bus.stop_ev |=> hs_q == $past(hs_q)) else $error("restart changed mode");

  // setup bit 1 low restores configuration
  cfg_reset_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    st_q == ACS_WRX && bus.scl_fall && bit_q == 4'h8 && shf_q[7] && !shf_q[1] && !bus.stop_ev
    && !bus.start_ev |=> config_q == `ACS_CONFIG_RESET) else $error("config not reset");

  // skipped traffic never drives the line
  skip_quiet_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    st_q == ACS_SKIP [*2] |-> !o_sda_oe) else $error("driving while ignoring");

  // first read bit is a leading one
  lead_one_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    st_q == ACS_AACK && rd_q && !mcode_q && bus.scl_fall && shf_q[7:1] == `ACS_SLAVE_ADDR
    && !bus.stop_ev && !bus.start_ev |=> st_q == ACS_RTX && !o_sda_oe) else $error("read lead bit low");
endmodule : acs_slave

// ---- verification/acs_master_model.sv ----
// two-wire bus master model: drives the clock pin and releases or pulls data
// assumes the bench resolves data with a pull-up and the slave's drive
`timescale 1ns/100ps
module acs_master_model (
  // pacing clock
  input wire logic i_clk_sys,
  // resolved data line level
  input wire logic i_sda_line,
  // driven pins, 1 on data means released
  output logic o_scl,
  output logic o_sda
);
  // bus idles with both lines high, the clock stands still outside frames
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // wait whole system clocks
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask : tick
  // one bit: data moves only while clock is low, 5 low plus 3 high = 160 ns
  // the long low phase leaves room for the slave to drop its ack first
  task automatic bit_io(input logic b, output logic r);
    o_scl <= 1'b0;
    tick(2);
    o_sda <= b;
    tick(3);
    o_scl <= 1'b1;
    tick(2);
    r = i_sda_line;
    tick(1);
  endtask : bit_io
  // start or repeated start: data falls while clock high
  task automatic start_cond;
    o_scl <= 1'b0;
    tick(2);
    o_sda <= 1'b1;
    tick(3);
    o_scl <= 1'b1;
    tick(2);
    o_sda <= 1'b0;
    tick(4); // clock held high long enough for the slave to register the start
  endtask : start_cond
  // stop: data rises while clock high, ends each test block after the reset check
  task automatic stop_cond;
    o_scl <= 1'b0;
    tick(2);
    o_sda <= 1'b0;
    tick(3);
    o_scl <= 1'b1;
    tick(2);
    o_sda <= 1'b1;
    tick(5); // the slave's registered state has settled before the caller looks
  endtask : stop_cond
  // eight bits msb first, then the ninth bit; a = 1 releases for slave ack
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic n);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(a, n);
  endtask : xfer
endmodule : acs_master_model

// ---- verification/acs_slave_test.sv ----
// self-checking bench for the two-wire slave front end
// assumes the master model paces the bus from the system clock
`timescale 1ns/100ps
module acs_slave_test;
  logic i_clk_sys;
  logic i_rst;
  logic i_scl;
  wire logic i_sda;
  logic m_sda; // master data drive, 1 released
  logic [9:0] i_result;
  logic o_sda;
  logic o_sda_oe;
  logic [2:0] o_reference_choice;
  logic o_clock_external;
  logic o_polarity_coding_select;
  logic [1:0] o_scan_pattern;
  logic o_input_channel_pick;
  logic o_input_type_select;
  logic o_high_speed;
  logic o_bus_active;
  logic [8:0] fld; // all decoded fields packed
  logic [7:0] q;
  logic n;
  int err_count;
  int compares;
  // open-drain wire with pull-up
  assign i_sda = o_sda_oe ? o_sda : m_sda;
  assign fld = {o_reference_choice, o_clock_external, o_polarity_coding_select,
                o_scan_pattern, o_input_channel_pick, o_input_type_select};
  acs_slave acs_slave_i (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda),
    .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_result(i_result),
    .o_reference_choice(o_reference_choice), .o_clock_external(o_clock_external),
    .o_polarity_coding_select(o_polarity_coding_select), .o_scan_pattern(o_scan_pattern),
    .o_input_channel_pick(o_input_channel_pick), .o_input_type_select(o_input_type_select),
    .o_high_speed(o_high_speed), .o_bus_active(o_bus_active)
  );
  acs_master_model acs_master_model_i (
    .i_clk_sys(i_clk_sys), .i_sda_line(i_sda), .o_scl(i_scl), .o_sda(m_sda)
  );
  // 50 MHz system clock
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  // verdict and end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  // case-equal compare, counted
  task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // write one byte and check the ninth-bit level seen on the wire
  task automatic wr(input logic [7:0] d, input logic ack_lvl);
    acs_master_model_i.xfer(d, 1'b1, q, n);
    chk({8'h00, n}, {8'h00, ack_lvl}, "ack level");
  endtask : wr
  // hang guard
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    err_count++;
    $display("[FAIL] %0t run timed out", $time);
    test_done();
  end
  initial begin
    err_count = 0;
    compares = 0;
    i_rst = 1'b1;
    i_result = 10'h000;
    repeat (6) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    chk(fld, 9'h001, "reset fields");
    chk({8'h00, o_high_speed}, 9'h000, "reset speed");
    $display("test reset done");
    // setup then configuration, stop
    acs_master_model_i.start_cond();
    chk({8'h00, o_bus_active}, 9'h001, "active");
    wr(8'h6C, 1'b0);
    wr(8'hFE, 1'b0);
    chk(fld, 9'h1F1, "setup stored");
    wr(8'h63, 1'b0);
    chk(fld, 9'h1FF, "config stored");
    acs_master_model_i.stop_cond();
    chk({8'h00, o_bus_active}, 9'h000, "idle");
    $display("test write pair done");
    // configuration then setup with reset bit clear, then restart
    acs_master_model_i.start_cond();
    wr(8'h6C, 1'b0);
    wr(8'h42, 1'b0);
    chk(fld, 9'h1FA, "config first");
    wr(8'h81, 1'b0);
    chk(fld, 9'h001, "config cleared");
    acs_master_model_i.start_cond();
    chk({8'h00, o_bus_active}, 9'h001, "restart active");
    wr(8'h50, 1'b1);
    wr(8'h00, 1'b1);
    chk(fld, 9'h001, "foreign ignored");
    acs_master_model_i.stop_cond();
    $display("test order and foreign done");
    // high-speed entry, restart keeps it, stop leaves it
    // the switch lands on the clock fall that ends the nack, inside the restart
    acs_master_model_i.start_cond();
    wr(8'h0D, 1'b1);
    acs_master_model_i.start_cond();
    chk({8'h00, o_high_speed}, 9'h001, "hs on");
    wr(8'h6C, 1'b0);
    chk({8'h00, o_high_speed}, 9'h001, "hs kept");
    wr(8'h20, 1'b0);
    chk(fld, 9'h004, "hs write");
    acs_master_model_i.stop_cond();
    chk({8'h00, o_high_speed}, 9'h000, "hs off");
    $display("test high speed done");
    // read: leading ones, msb first, master nack ends it
    i_result <= 10'h2A5;
    acs_master_model_i.start_cond();
    wr(8'h6D, 1'b0);
    acs_master_model_i.xfer(8'hFF, 1'b0, q, n);
    chk({1'b0, q}, 9'h0FE, "read high");
    acs_master_model_i.xfer(8'hFF, 1'b1, q, n);
    chk({1'b0, q}, 9'h0A5, "read low");
    acs_master_model_i.stop_cond();
    $display("test read done");
    test_done();
  end
endmodule : acs_slave_test
